// ### hw/cmd_regs.svh
`ifndef CMD_REGS_SVH
`define CMD_REGS_SVH

// Width of the input period counter, in bits.
`define CMD_CNT_W 16
// Core clock multiplication factor against the input clock.
`define CMD_CORE_MULT 4
// Core half periods per input period, and the last index among them.
`define CMD_HALF_STEPS 8
`define CMD_SUB_LAST 3'h7
// Shift that turns one input period into one core half period.
`define CMD_SEG_SHIFT 3
// Input edges needed before the period measurement is trusted.
`define CMD_LOCK_EDGES 2'h2
// Number of divide-by-two stages after the core clock.
`define CMD_DIV_STAGES 2
// Stage index of the peripheral clock and of the half-rate clock.
`define CMD_PERIPH_STAGE 0
`define CMD_HALF_STAGE 1
// Rate of clk, for reference by the bench.
`define CMD_CLK_HZ 50000000

`endif

// ### hw/cmd_pkg.sv
package cmd_pkg;
    `include "cmd_regs.svh"

    typedef logic [`CMD_CNT_W-1:0] cmd_cnt_t;

    // Whole state of the multiplier front end.
    typedef struct packed {
        logic in_prev;
        cmd_cnt_t cnt;
        cmd_cnt_t period;
        cmd_cnt_t seg_cnt;
        logic [2:0] sub;
        logic [1:0] edges;
        logic core;
        logic locked;
    } cmd_state_s;

    // State of one divide-by-two stage.
    typedef struct packed {
        logic q;
    } cmd_div_s;
endpackage

// ### hw/cmd_div2.sv
`timescale 1ns/1ns
module cmd_div2
    import cmd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Rising edge of the faster clock, valid in the cycle before it shows
    input wire logic in_rise_nxt,
    // Divided clock and its own early rising edge
    output logic q,
    output logic out_rise_nxt
);
    cmd_div_s s_r;
    cmd_div_s s_nxt;

    // Toggling only on the faster clock's rise keeps both edges aligned.
    always_comb begin
        s_nxt = s_r;
        out_rise_nxt = in_rise_nxt & ~s_r.q;
        if (in_rise_nxt) begin
            s_nxt.q = ~s_r.q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.q;
endmodule

// ### hw/cmd_clock_gen.sv
`timescale 1ns/1ns
// How it works
// RULE_01 - The core clock runs at exactly four times the input clock rate.
// RULE_02 - The peripheral clock runs at twice the input rate, half the core.
// RULE_03 - The peripheral clock is the one handed to peripherals and bus.
// RULE_04 - The clock output pin carries a clock at the peripheral rate.
// RULE_05 - A half-rate peripheral clock feeds the timer and its sampling.
// RULE_06 - Derived clocks come from synchronous division of the core clock.
module cmd_clock_gen
    import cmd_pkg::*;
#(
    parameter int MIN_PERIOD = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // External input clock, sampled on clk
    input wire logic clk_in,
    // Generated clocks
    output logic core_clock,
    output logic periph_clock,
    output logic clock_out_pin,
    output logic half_clock,
    // Status
    output logic locked
);
    localparam int MAX_PERIOD = (1 << `CMD_CNT_W) - 1;
    localparam int SEG_STEPS = 1 << `CMD_SEG_SHIFT;

    // Each core half period needs at least one clk cycle.
    localparam bit BAD_MIN = (MIN_PERIOD < `CMD_HALF_STEPS) ||
        (MIN_PERIOD > MAX_PERIOD);
    if (BAD_MIN) begin : g_bad_min
        $error("MIN_PERIOD out of range");
    end

    // Two half periods make one core period.
    localparam bit BAD_STEPS = (`CMD_HALF_STEPS != 2 * `CMD_CORE_MULT);
    if (BAD_STEPS) begin : g_bad_steps
        $error("half step count does not match the multiplier");
    end

    // The period shift must split one input period into the half steps.
    localparam bit BAD_SHIFT = (SEG_STEPS != `CMD_HALF_STEPS);
    if (BAD_SHIFT) begin : g_bad_shift
        $error("segment shift does not match the half step count");
    end

    // The step index is three bits wide and must end on the last step.
    localparam bit BAD_SUB = (int'(`CMD_SUB_LAST) != `CMD_HALF_STEPS - 1);
    if (BAD_SUB) begin : g_bad_sub
        $error("last half step index does not match the step count");
    end

    // The peripheral stage must come before the half-rate stage.
    localparam bit BAD_STAGES = (`CMD_PERIPH_STAGE >= `CMD_HALF_STAGE) ||
        (`CMD_HALF_STAGE >= `CMD_DIV_STAGES);
    if (BAD_STAGES) begin : g_bad_stages
        $error("divider stage indices out of order");
    end

    // A lock needs at least one trusted period after the first edge.
    localparam bit BAD_LOCK = (`CMD_LOCK_EDGES == 2'h0);
    if (BAD_LOCK) begin : g_bad_lock
        $error("lock edge count must not be zero");
    end

    localparam cmd_cnt_t MIN_P = cmd_cnt_t'(MIN_PERIOD);
    localparam cmd_cnt_t ONE = cmd_cnt_t'(1);

    // Registered state and its next value.
    cmd_state_s s_r;
    cmd_state_s s_nxt;
    cmd_state_s s_rst;

    // Period arithmetic.
    cmd_cnt_t seg;
    cmd_cnt_t cnt_inc;
    cmd_cnt_t seg_load;
    cmd_cnt_t seg_dec;

    // Decisions taken from the current state.
    logic in_edge;
    logic stopped;
    logic period_ok;
    logic lock_next;
    logic seg_done;
    logic phase_run;
    logic [1:0] edges_inc;
    logic [2:0] sub_inc;

    // Divider chain.
    logic core_rise_nxt;
    logic [`CMD_DIV_STAGES:0] rise_chain;
    logic [`CMD_DIV_STAGES-1:0] div_q;

    // The core half period is the last measured input period over eight.
    // A period that is not a multiple of eight stretches the final low
    // phase; that is the price of a clock built from whole clk cycles.
    assign seg = s_r.period >> `CMD_SEG_SHIFT;
    assign seg_load = seg - ONE;
    assign seg_dec = s_r.seg_cnt - ONE;
    assign seg_done = (s_r.seg_cnt == '0);

    assign cnt_inc = s_r.cnt + ONE;
    assign stopped = (s_r.cnt == '1);

    assign in_edge = clk_in & ~s_r.in_prev;

    assign period_ok = (s_r.period >= MIN_P);
    assign lock_next = (s_r.edges == `CMD_LOCK_EDGES) && period_ok;

    assign phase_run = s_r.locked && (s_r.sub != `CMD_SUB_LAST);

    assign edges_inc = s_r.edges + 2'h1;
    assign sub_inc = s_r.sub + 3'h1;

    always_comb begin
        s_rst = '0;
        // Starting from the pin's level avoids a false edge after reset.
        s_rst.in_prev = clk_in;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.in_prev = clk_in;

        if (!stopped) begin
            s_nxt.cnt = cnt_inc;
        end

        if (in_edge) begin
            // Each input edge restarts the core phase, so drift cannot grow.
            s_nxt.period = cnt_inc;
            s_nxt.cnt = '0;
            if (s_r.edges != `CMD_LOCK_EDGES) begin
                s_nxt.edges = edges_inc;
            end
            s_nxt.locked = lock_next;
            s_nxt.sub = '0;
            s_nxt.seg_cnt = seg_load;
            // RULE_01 core phase start
            s_nxt.core = lock_next;
        end else if (stopped) begin
            // Input has stopped; drop lock rather than run on a stale period.
            s_nxt.locked = 1'b0;
            s_nxt.edges = '0;
            s_nxt.core = 1'b0;
        end else if (phase_run) begin
            if (seg_done) begin
                // RULE_01 eight half periods
                s_nxt.core = ~s_r.core;
                s_nxt.sub = sub_inc;
                s_nxt.seg_cnt = seg_load;
            end else begin
                s_nxt.seg_cnt = seg_dec;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= s_rst;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign core_rise_nxt = s_nxt.core & ~s_r.core;
    assign rise_chain[0] = core_rise_nxt;

    // RULE_06 synchronous divide chain
    for (genvar i = 0; i < `CMD_DIV_STAGES; i++) begin : g_div
        cmd_div2 u_div (
            .clk(clk),
            .rst(rst),
            .in_rise_nxt(rise_chain[i]),
            .q(div_q[i]),
            .out_rise_nxt(rise_chain[i+1])
        );
    end

    assign core_clock = s_r.core;
    // RULE_02 core divided by two
    // RULE_03 peripheral clock output
    assign periph_clock = div_q[`CMD_PERIPH_STAGE];
    // RULE_04 pin follows peripheral clock
    assign clock_out_pin = div_q[`CMD_PERIPH_STAGE];
    // RULE_05 peripheral divided by two
    assign half_clock = div_q[`CMD_HALF_STAGE];
    assign locked = s_r.locked;
endmodule

// ### tb/cmd_clock_gen_properties.sv
`timescale 1ns/1ns
module cmd_clock_gen_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched outputs
    input wire logic core_clock,
    input wire logic periph_clock,
    input wire logic clock_out_pin,
    input wire logic half_clock,
    input wire logic locked
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    core_gate_a: assert property (!locked |-> !core_clock)
        else $error("core clock runs while unlocked");
    periph_sync_a: assert property (
        $changed(periph_clock) |-> $rose(core_clock))
        else $error("peripheral clock moved off a core rise");
    periph_rate_a: assert property (
        $rose(core_clock) |-> $changed(periph_clock))
        else $error("peripheral clock missed a core rise");
    pin_match_a: assert property (
        clock_out_pin == periph_clock)
        else $error("clock pin differs from peripheral clock");
    half_rate_a: assert property (
        $changed(half_clock) |-> $rose(periph_clock))
        else $error("half clock moved off a peripheral rise");
    divider_freeze_a: assert property (
        !locked |-> $stable(periph_clock) && $stable(half_clock))
        else $error("divided clocks moved while unlocked");
    cover property (locked);
    cover property ($rose(periph_clock));
    cover property ($rose(half_clock));
endmodule
bind cmd_clock_gen cmd_clock_gen_chk cmd_clock_gen_chk_inst (
    .clk(clk), .rst(rst), .core_clock(core_clock),
    .periph_clock(periph_clock), .clock_out_pin(clock_out_pin),
    .half_clock(half_clock), .locked(locked));

// ### tb/cmd_src.sv
`timescale 1ns/1ns
module cmd_src (
    // Clock
    input wire logic clk,
    // Input period in clk cycles
    input wire logic [15:0] period,
    // Generated input clock
    output logic clk_in = 1'b0
);
    logic [15:0] cnt_r = 16'h0;
    always @(posedge clk) begin
        cnt_r <= (cnt_r + 16'h1 >= period) ? 16'h0 : cnt_r + 16'h1;
        clk_in <= cnt_r < (period >> 1);
    end
endmodule

// ### tb/cmd_clock_gen_bench.sv
`timescale 1ns/1ns
module cmd_clock_gen_bench;
    import cmd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] period = 16'h10;
    logic clk_in, core_clock, periph_clock, clock_out_pin, half_clock, locked;
    int fail_count = 0;
    int comparisons = 0;
    initial begin
        forever #10 clk = ~clk;
    end
    cmd_src cmd_src_inst (.clk(clk), .period(period), .clk_in(clk_in));
    cmd_clock_gen #(.MIN_PERIOD(16)) cmd_clock_gen_inst (.clk(clk),
        .rst(rst), .clk_in(clk_in), .core_clock(core_clock),
        .periph_clock(periph_clock), .clock_out_pin(clock_out_pin),
        .half_clock(half_clock), .locked(locked));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Window of four whole input periods, so edge counts are phase free.
    task automatic test_rate(input logic [15:0] p);
        logic [7:0] nc, np, nh;
        logic pc, pp, ph;
        @(posedge clk);
        period <= p;
        repeat (3 * p) @(posedge clk);
        #1;
        check({7'h0, locked}, 8'h01);
        {nc, np, nh} = 24'h0;
        {pc, pp, ph} = {core_clock, periph_clock, half_clock};
        repeat (4 * p) begin
            @(posedge clk);
            #1;
            nc += {7'h0, core_clock & ~pc};
            np += {7'h0, periph_clock & ~pp};
            nh += {7'h0, half_clock & ~ph};
            {pc, pp, ph} = {core_clock, periph_clock, half_clock};
        end
        check(nc, 8'h10);
        check(np, 8'h08);
        check(nh, 8'h04);
        $display("rate test done, period %0d", p);
    endtask
    // An input faster than the minimum must not clock the core.
    task automatic test_short();
        @(posedge clk);
        period <= 16'h8;
        repeat (80) @(posedge clk);
        #1;
        check({6'h0, locked, core_clock}, 8'h00);
        $display("short period test done");
    endtask
    initial begin
        #40000;
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        test_rate(16'h10);
        test_rate(16'h14);
        test_short();
        stop_test();
    end
endmodule
